// ===== design/bsr_pkg.sv
// Shared constants and carrier types for the serial boot flash read engine
package bsr_pkg;
	// Accepted first matching byte values
	localparam logic [7:0] BSR_MATCH1_A = 8'h86;
	localparam logic [7:0] BSR_MATCH1_B = 8'h30;
	// Accepted second matching byte values
	localparam logic [7:0] BSR_MATCH2_A = 8'h79;
	localparam logic [7:0] BSR_MATCH2_B = 8'hCF;
	// Read operation code
	localparam logic [7:0] BSR_OP_READ = 8'h40;
	// Error bytes, each sent three times before lock-up
	localparam logic [7:0] BSR_ERR_COMM = 8'hA1;
	localparam logic [7:0] BSR_ERR_CMD = 8'h63;
	// Repeat count of an error byte
	localparam logic [1:0] BSR_ERR_REPEAT = 2'h3;
	// Count value that is never legal
	localparam logic [23:0] BSR_CNT_ZERO = 24'h000000;
	// Bytes in one address pair or address plus count field
	localparam logic [2:0] BSR_FIELD_BYTES = 3'h6;
	// Default internal memory size in bytes (plain default)
	localparam logic [23:0] BSR_MEM_BYTES_DEF = 24'h010000;
	// Reset values
	localparam logic [15:0] BSR_SUM_RST = 16'h0000;
	localparam logic [23:0] BSR_ADDR_RST = 24'h000000;

	// Engine states
	typedef enum logic [4:0] {
		BSR_MATCH1, BSR_ECHO1, BSR_MATCH2, BSR_ECHO2, BSR_WAIT_OP, BSR_ECHO_OP,
		BSR_ERR_TX, BSR_PW_ADDR, BSR_PW_CNT_RD, BSR_PW_STR_RX, BSR_PW_CMP_RD,
		BSR_RD_FIELD, BSR_STREAM, BSR_CK_HI, BSR_CK_LO, BSR_LOCKED
	} bsr_state_e;

	// Received byte from the serial receiver
	typedef struct packed {
		logic valid;
		logic err;
		logic [7:0] data;
	} bsr_rx_s;

	// Byte offered to the serial transmitter
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} bsr_tx_s;

	// Whole engine state
	typedef struct packed {
		bsr_state_e st;
		logic [2:0] idx;
		logic [47:0] fld;
		logic [23:0] cmp_addr;
		logic [7:0] pw_len;
		logic [7:0] hold;
		logic [23:0] addr;
		logic [23:0] remain;
		logic [15:0] sum;
		logic [1:0] err_n;
		logic mem_req;
		logic [7:0] buf0;
		logic [7:0] buf1;
		logic [1:0] cnt;
		logic tx_valid;
		logic locked;
	} bsr_regs_s;
endpackage : bsr_pkg

// ===== design/bsr_engine.sv
// Byte engine for the serial boot flash read command
//
// Overview of operation
// - First matching byte echoed, silent on failure
// - Second matching byte echoed, silent on failure
// - Read operation code echoed when accepted
// - Rejected code: error byte thrice, then idle
// - Erased vector region skips password check
// - Bad password address locks device idle
// - Security enabled refuses read, goes idle
// - Receive error in password phase: idle
// - Zero or oversize count locks device idle
// - Stream memory bytes, then checksum high, low
// - After checksum, wait for next operation code
`timescale 1ns/10ps
module bsr_engine
	import bsr_pkg::*;
#(
	parameter logic [23:0] MEM_BYTES = BSR_MEM_BYTES_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire bsr_rx_s rx,
	output bsr_tx_s tx,
	input wire logic tx_ready,
	output logic mem_req,
	output logic [23:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	input wire logic vectors_blank,
	input wire logic security_on,
	output logic locked
);

	// Current and next engine state
	bsr_regs_s r_reg;
	bsr_regs_s r_next;
	// Byte handed to the output buffer this cycle
	logic push_en;
	logic [7:0] push_byte;
	// Buffer has a free entry after this cycle's pop
	logic room;
	// Fields as they stand after this cycle's shift; built from the
	// registered copy so the next-state logic never loops back on itself
	logic [23:0] fld_hi;
	logic [23:0] fld_lo;

	assign fld_hi = r_reg.fld[39:16];
	assign fld_lo = {r_reg.fld[15:0], rx.data};

	// Outputs straight from flops
	assign tx = '{valid: r_reg.tx_valid, data: r_reg.buf0};
	assign mem_req = r_reg.mem_req;
	assign mem_addr = r_reg.addr;
	assign locked = r_reg.locked;

	// Next-state logic: buffer pop, protocol step, buffer push
	always_comb begin
		r_next = r_reg;
		push_en = 1'b0;
		push_byte = 8'h00;
		// Pop first so a slot freed by this cycle's pop can take a push in the same cycle
		if (r_reg.tx_valid && tx_ready) begin
			r_next.buf0 = r_reg.buf1;
			r_next.cnt = r_reg.cnt - 2'h1;
		end
		room = (r_next.cnt != 2'h2);

		unique case (r_reg.st)
			// First matching byte, baud already tuned by the receiver
			BSR_MATCH1: begin
				if (rx.valid && !rx.err &&
					(rx.data == BSR_MATCH1_A || rx.data == BSR_MATCH1_B)) begin
					r_next.hold = rx.data;
					r_next.st = BSR_ECHO1;
				end
			end
			// Echo waits for buffer space
			BSR_ECHO1: begin
				if (room) begin
					push_en = 1'b1;
					push_byte = r_reg.hold;
					r_next.st = BSR_MATCH2;
				end
			end
			// Second matching byte; a bad one is dropped silently
			BSR_MATCH2: begin
				if (rx.valid && !rx.err &&
					(rx.data == BSR_MATCH2_A || rx.data == BSR_MATCH2_B)) begin
					r_next.hold = rx.data;
					r_next.st = BSR_ECHO2;
				end
			end
			BSR_ECHO2: begin
				if (room) begin
					push_en = 1'b1;
					push_byte = r_reg.hold;
					r_next.st = BSR_WAIT_OP;
				end
			end
			// Operation code
			BSR_WAIT_OP: begin
				if (rx.valid) begin
					r_next.err_n = BSR_ERR_REPEAT;
					if (rx.err) begin
						// receive fault answered with error byte
						r_next.hold = BSR_ERR_COMM;
						r_next.st = BSR_ERR_TX;
					end else if (rx.data == BSR_OP_READ) begin
						r_next.st = BSR_ECHO_OP;
					end else begin
						r_next.hold = BSR_ERR_CMD;
						r_next.st = BSR_ERR_TX;
					end
				end
			end
			BSR_ECHO_OP: begin
				if (room) begin
					push_en = 1'b1;
					push_byte = BSR_OP_READ;
					r_next.idx = 3'h0;
					r_next.st = BSR_PW_ADDR;
				end
			end
			// Error byte three times, then lock
			BSR_ERR_TX: begin
				if (room) begin
					push_en = 1'b1;
					push_byte = r_reg.hold;
					r_next.err_n = r_reg.err_n - 2'h1;
					if (r_reg.err_n == 2'h1) begin
						r_next.st = BSR_LOCKED;
					end
				end
			end
			// Count address then compare address, high byte first
			BSR_PW_ADDR: begin
				if (rx.valid) begin
					if (rx.err) begin
						r_next.st = BSR_LOCKED;
					end else begin
						r_next.fld = {r_reg.fld[39:0], rx.data};
						r_next.idx = r_reg.idx + 3'h1;
						if (r_reg.idx == BSR_FIELD_BYTES - 3'h1) begin
							// address outside memory is a password error
							if (fld_hi >= MEM_BYTES || fld_lo >= MEM_BYTES) begin
								r_next.st = BSR_LOCKED;
							end else if (vectors_blank) begin
								r_next.idx = 3'h0;
								r_next.st = security_on ? BSR_LOCKED : BSR_RD_FIELD;
							end else begin
								// fetch string length at count address
								r_next.cmp_addr = fld_lo;
								r_next.addr = fld_hi;
								r_next.mem_req = 1'b1;
								r_next.st = BSR_PW_CNT_RD;
							end
						end
					end
				end
			end
			// Length of the password string from memory
			BSR_PW_CNT_RD: begin
				// Input bytes here are ignored; host waits on the read
				if (mem_ack) begin
					r_next.mem_req = 1'b0;
					r_next.pw_len = mem_rdata;
					// empty length treated as bad count address
					r_next.st = (mem_rdata == 8'h00) ? BSR_LOCKED : BSR_PW_STR_RX;
				end
			end
			// One password byte, then compare against memory
			BSR_PW_STR_RX: begin
				if (rx.valid) begin
					if (rx.err) begin
						r_next.st = BSR_LOCKED;
					end else begin
						r_next.hold = rx.data;
						r_next.addr = r_reg.cmp_addr;
						r_next.mem_req = 1'b1;
						r_next.st = BSR_PW_CMP_RD;
					end
				end
			end
			BSR_PW_CMP_RD: begin
				if (mem_ack) begin
					r_next.mem_req = 1'b0;
					r_next.cmp_addr = r_reg.cmp_addr + 24'h000001;
					r_next.pw_len = r_reg.pw_len - 8'h01;
					if (mem_rdata != r_reg.hold) begin
						r_next.st = BSR_LOCKED;
					end else if (r_reg.pw_len == 8'h01) begin
						r_next.idx = 3'h0;
						r_next.st = security_on ? BSR_LOCKED : BSR_RD_FIELD;
					end else begin
						r_next.st = BSR_PW_STR_RX;
					end
				end
			end
			// Start address then byte count, high byte first
			BSR_RD_FIELD: begin
				if (rx.valid) begin
					// A fault here has no answer; lock silently
					if (rx.err) begin
						r_next.st = BSR_LOCKED;
					end else begin
						r_next.fld = {r_reg.fld[39:0], rx.data};
						r_next.idx = r_reg.idx + 3'h1;
						if (r_reg.idx == BSR_FIELD_BYTES - 3'h1) begin
							if (fld_lo == BSR_CNT_ZERO || fld_lo > MEM_BYTES) begin
								r_next.st = BSR_LOCKED;
							end else begin
								r_next.addr = fld_hi;
								r_next.remain = fld_lo;
								r_next.sum = BSR_SUM_RST;
								r_next.st = BSR_STREAM;
							end
						end
					end
				end
			end
			// Memory bytes, one read in flight at most
			BSR_STREAM: begin
				if (r_reg.mem_req) begin
					if (mem_ack) begin
						// forward byte; room was checked at request
						push_en = 1'b1;
						push_byte = mem_rdata;
						r_next.sum = r_reg.sum + {8'h00, mem_rdata};
						r_next.mem_req = 1'b0;
						r_next.addr = r_reg.addr + 24'h000001;
						r_next.remain = r_reg.remain - 24'h000001;
					end
				end else if (r_reg.remain == BSR_ADDR_RST) begin
					r_next.st = BSR_CK_HI;
				end else if (room) begin
					r_next.mem_req = 1'b1;
				end
			end
			BSR_CK_HI: begin
				if (room) begin
					push_en = 1'b1;
					push_byte = r_reg.sum[15:8];
					r_next.st = BSR_CK_LO;
				end
			end
			BSR_CK_LO: begin
				// low byte, then back to the command wait
				if (room) begin
					push_en = 1'b1;
					push_byte = r_reg.sum[7:0];
					r_next.st = BSR_WAIT_OP;
				end
			end
			// Lock-up; only the reset pin leaves it
			BSR_LOCKED: begin
				r_next.mem_req = 1'b0;
			end
		endcase

		// Write into the first free entry
		if (push_en) begin
			if (r_next.cnt == 2'h0) begin
				r_next.buf0 = push_byte;
			end else begin
				r_next.buf1 = push_byte;
			end
			r_next.cnt = r_next.cnt + 2'h1;
		end
		r_next.tx_valid = (r_next.cnt != 2'h0);
		r_next.locked = (r_next.st == BSR_LOCKED);
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_reg <= '{st: BSR_MATCH1, idx: 3'h0, fld: 48'h000000000000,
				cmp_addr: BSR_ADDR_RST, pw_len: 8'h00, hold: 8'h00,
				addr: BSR_ADDR_RST, remain: BSR_ADDR_RST, sum: BSR_SUM_RST,
				err_n: 2'h0, mem_req: 1'b0, buf0: 8'h00, buf1: 8'h00,
				cnt: 2'h0, tx_valid: 1'b0, locked: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

endmodule : bsr_engine

// ===== bench/bsr_mem_model.sv
// Behavioural flash array answering the engine's read requests
`timescale 1ns/10ps
module bsr_mem_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic mem_req,
	input wire logic [23:0] mem_addr,
	output logic mem_ack,
	output logic [7:0] mem_rdata
);
	logic [1:0] wait_reg; // Cycles waited on this request
	// Delay follows low address bits, so prompt and slow answers mix
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_reg <= 2'h0;
			mem_ack <= 1'b0;
			mem_rdata <= 8'h00;
		end else if (mem_req && !mem_ack && wait_reg >= mem_addr[1:0]) begin
			wait_reg <= 2'h0;
			mem_ack <= 1'b1;
			mem_rdata <= mem_addr[7:0] ^ 8'h5A;
		end else begin
			wait_reg <= (mem_req && !mem_ack) ? wait_reg + 2'h1 : 2'h0;
			mem_ack <= 1'b0;
			// Stale data flips, so it never passes for a fresh read
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule : bsr_mem_model

// ===== bench/bsr_engine_monitor.sv
// Port assertions for the read engine
`timescale 1ns/10ps
module bsr_engine_monitor
	import bsr_pkg::*;
#(
	parameter logic [23:0] MEM_BYTES = BSR_MEM_BYTES_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire bsr_rx_s rx,
	input wire bsr_tx_s tx,
	input wire logic tx_ready,
	input wire logic mem_req,
	input wire logic [23:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	input wire logic vectors_blank,
	input wire logic security_on,
	input wire logic locked
);
	logic seen_reg; // Until a byte is offered, only the first match byte is awaited
	logic m1_ok; // Byte is an accepted first match value
	assign m1_ok = rx.data == BSR_MATCH1_A || rx.data == BSR_MATCH1_B;
	// Latch first output; cleared only by reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seen_reg <= 1'b0;
		end else if (tx.valid) begin
			seen_reg <= 1'b1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_m1_echo: assert property (
		rx.valid && !rx.err && !seen_reg && m1_ok |-> ##2 tx.valid && tx.data == $past(rx.data, 2))
		else $error("first match byte not echoed");
	a_m1_silent: assert property (
		rx.valid && !seen_reg && !m1_ok |=> !tx.valid [*3])
		else $error("bad first match byte answered");
	a_tx_hold: assert property (
		tx.valid && !tx_ready |=> tx.valid && $stable(tx.data))
		else $error("offered byte lost or changed");
	a_mem_hold: assert property (
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("memory request dropped early");
	a_mem_drop: assert property (
		mem_req && mem_ack |=> !mem_req)
		else $error("memory request held after ack");
	a_lock_stays: assert property (
		locked |=> locked)
		else $error("lock left without reset");
	a_lock_quiet: assert property (
		locked && !tx.valid |=> !tx.valid)
		else $error("locked engine transmits");
	a_lock_no_mem: assert property (
		locked |-> !mem_req)
		else $error("locked engine reads memory");
	c_lock: cover property ($rose(locked));
	c_mem: cover property (mem_req && mem_ack);
	c_stall: cover property (tx.valid && !tx_ready);
endmodule : bsr_engine_monitor

bind bsr_engine bsr_engine_monitor #(.MEM_BYTES(MEM_BYTES)) u_mon (.clk(clk), .rst(rst),
	.rx(rx), .tx(tx), .tx_ready(tx_ready), .mem_req(mem_req), .mem_addr(mem_addr),
	.mem_ack(mem_ack), .mem_rdata(mem_rdata), .vectors_blank(vectors_blank),
	.security_on(security_on), .locked(locked));

// ===== bench/tb_top.sv
// Self-checking bench for the read engine
`timescale 1ns/10ps
module tb_top;
	import bsr_pkg::*;
	localparam logic [23:0] MB = 24'h000100; // Small memory keeps runs short
	logic clk, rst, tx_ready, stall, mem_req, mem_ack, vectors_blank, security_on, locked;
	logic [23:0] mem_addr;
	logic [7:0] mem_rdata;
	logic [2:0] st_cnt; // Paces a slow receiver
	bsr_rx_s rx;
	bsr_tx_s tx;
	logic [7:0] q[$]; // Bytes taken from the transmitter
	int n_errors = 0;
	int comparisons = 0;
	bsr_engine #(.MEM_BYTES(MB)) DUT (.clk(clk), .rst(rst), .rx(rx), .tx(tx),
		.tx_ready(tx_ready), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .vectors_blank(vectors_blank), .security_on(security_on),
		.locked(locked));
	bsr_mem_model u_mem (.clk(clk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Collect bytes; a stalled receiver takes one in eight cycles
	always @(posedge clk) begin
		if (tx.valid === 1'b1 && tx_ready === 1'b1) begin
			q.push_back(tx.data);
		end
		st_cnt <= st_cnt + 3'h1;
		tx_ready <= !stall || st_cnt == 3'h0;
	end
	function automatic logic [7:0] mdat(logic [23:0] a);
		return a[7:0] ^ 8'h5A;
	endfunction : mdat
	task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic send(logic [7:0] b, logic e);
		rx <= '{1'b1, e, b};
		@(posedge clk);
		rx.valid <= 1'b0;
		@(posedge clk);
	endtask : send
	// Whole 24-bit field, high byte first
	task automatic put3(logic [23:0] v);
		for (int i = 2; i >= 0; i--) send(v[8*i+:8], 1'b0);
	endtask : put3
	task automatic restart(logic blank, logic sec);
		rst <= 1'b1;
		vectors_blank <= blank;
		security_on <= sec;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		q.delete();
	endtask : restart
	// Wait for bytes, then a quiet spell to catch extras
	task automatic expect_q(string what, logic [7:0] e[$]);
		for (int i = 0; i < 3000 && q.size() < e.size(); i++) @(posedge clk);
		repeat (20) @(posedge clk);
		chk({what, " count"}, 24'(e.size()), 24'(q.size()));
		for (int i = 0; i < e.size() && i < q.size(); i++) chk(what, 24'(e[i]), 24'(q[i]));
		q.delete();
	endtask : expect_q
	task automatic body(logic blank, logic [23:0] a, logic [23:0] n, logic slow);
		logic [7:0] e[$];
		logic [15:0] s;
		s = 16'h0000;
		put3(24'h00005B);
		put3(24'h000020);
		if (!blank) begin
			// Engine ignores bytes while it reads memory, so wait out each read
			repeat (8) @(posedge clk);
			send(8'h7A, 1'b0);
			repeat (8) @(posedge clk);
		end
		put3(a);
		put3(n);
		stall <= slow;
		for (int i = 0; i < n; i++) begin
			e.push_back(mdat(a + 24'(i)));
			s = s + 16'(mdat(a + 24'(i)));
		end
		e.push_back(s[15:8]);
		e.push_back(s[7:0]);
		expect_q("stream", e);
		stall <= 1'b0;
	endtask : body
	task automatic t_read(logic [7:0] m1, logic [7:0] m2);
		restart(1'b1, 1'b0);
		send(m1, 1'b0);
		send(m2, 1'b0);
		send(BSR_OP_READ, 1'b0);
		expect_q("echo", '{m1, m2, BSR_OP_READ});
		body(1'b1, 24'h000010, 24'h000004, 1'b0);
		vectors_blank <= 1'b0;
		send(BSR_OP_READ, 1'b0);
		expect_q("reecho", '{BSR_OP_READ});
		body(1'b0, 24'h000000, MB, 1'b1);
		$display("read test done");
	endtask : t_read
	task automatic t_bad_op(logic e, logic [7:0] code);
		restart(1'b1, 1'b0);
		send(8'h55, 1'b0);
		send(BSR_MATCH1_A, 1'b0);
		send(8'h12, 1'b0);
		send(BSR_MATCH2_B, 1'b0);
		send(8'h41, e);
		expect_q("error", '{BSR_MATCH1_A, BSR_MATCH2_B, code, code, code});
		chk("locked", 24'h1, 24'(locked));
		send(BSR_MATCH1_A, 1'b0);
		expect_q("idle", '{});
		$display("bad opcode test done");
	endtask : t_bad_op
	task automatic t_lock(logic sec, logic e, logic [23:0] pwa, logic [23:0] n);
		restart(1'b1, sec);
		send(BSR_MATCH1_B, 1'b0);
		send(BSR_MATCH2_A, 1'b0);
		send(BSR_OP_READ, 1'b0);
		send(pwa[23:16], e);
		send(pwa[15:8], 1'b0);
		send(pwa[7:0], 1'b0);
		put3(24'h000020);
		put3(24'h000010);
		put3(n);
		expect_q("lock", '{BSR_MATCH1_B, BSR_MATCH2_A, BSR_OP_READ});
		chk("locked", 24'h1, 24'(locked));
		$display("lock test done");
	endtask : t_lock
	// Faults found only after the length read: bad string, zero length, security
	task automatic t_pw_lock(logic sec, logic [23:0] ca, logic [7:0] pw);
		restart(1'b0, sec);
		send(BSR_MATCH1_A, 1'b0);
		send(BSR_MATCH2_B, 1'b0);
		send(BSR_OP_READ, 1'b0);
		put3(ca);
		put3(24'h000020);
		repeat (8) @(posedge clk);
		send(pw, 1'b0);
		repeat (8) @(posedge clk);
		put3(24'h000010);
		put3(24'h000004);
		expect_q("pw lock", '{BSR_MATCH1_A, BSR_MATCH2_B, BSR_OP_READ});
		chk("pw locked", 24'h1, 24'(locked));
		$display("password lock test done");
	endtask : t_pw_lock
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done
	// Watchdog well beyond the expected run length
	initial begin
		#(100 * 60000);
		n_errors++;
		test_done();
	end
	initial begin
		rst = 1'b1;
		stall = 1'b0;
		st_cnt = 3'h0;
		tx_ready = 1'b1;
		rx = '0;
		vectors_blank = 1'b1;
		security_on = 1'b0;
		t_read(BSR_MATCH1_A, BSR_MATCH2_A);
		t_read(BSR_MATCH1_B, BSR_MATCH2_B);
		t_bad_op(1'b0, BSR_ERR_CMD);
		t_bad_op(1'b1, BSR_ERR_COMM);
		t_lock(1'b0, 1'b0, MB, 24'h000004);
		t_lock(1'b1, 1'b0, 24'h00005B, 24'h000004);
		t_lock(1'b0, 1'b1, 24'h00005B, 24'h000004);
		t_lock(1'b0, 1'b0, 24'h00005B, BSR_CNT_ZERO);
		t_lock(1'b0, 1'b0, 24'h00005B, MB + 24'h000001);
		t_pw_lock(1'b0, 24'h00005B, 8'h7B);
		t_pw_lock(1'b0, 24'h00005A, 8'h7A);
		t_pw_lock(1'b1, 24'h00005B, 8'h7A);
		test_done();
	end
endmodule : tb_top
